// ---- rtl/light_check_bits.sv ----
`default_nettype none

module light_check_bits
  import light_result_pkg::*;
(
  input  wire logic [light_result_pkg::EXP_W-1:0]  exp_in,
  input  wire logic [light_result_pkg::MANT_W-1:0] mant_in,
  input  wire logic [light_result_pkg::CNT_W-1:0]  cnt_in,
  output logic      [light_result_pkg::CHK_W-1:0]  chk_out
);

  always_comb
  begin
    chk_out[0] = ^{exp_in, mant_in, cnt_in};
    chk_out[1] = ^{cnt_in[1], cnt_in[3], mant_in[1], mant_in[3], mant_in[5], mant_in[7], mant_in[9],
                   mant_in[11], mant_in[13], mant_in[15], mant_in[17], mant_in[19], exp_in[1], exp_in[3]};
    chk_out[2] = ^{cnt_in[3], mant_in[3], mant_in[7], mant_in[11], mant_in[15], mant_in[19], exp_in[3]};
    chk_out[3] = ^{mant_in[3], mant_in[11], mant_in[19]};
  end

endmodule

`default_nettype wire

// ---- rtl/light_result_fifo_regs.sv ----

`default_nettype none

module light_result_fifo_regs
  import light_result_pkg::*;
(
  input  wire logic                                clk,
  input  wire logic                                rst,
  input  wire logic                                ce,
  input  wire logic                                conv_valid,
  input  wire logic [light_result_pkg::EXP_W-1:0]  conv_exp,
  input  wire logic [light_result_pkg::MANT_W-1:0] conv_light_fraction,
  input  wire logic [light_result_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic                                reg_wr,
  input  wire logic [light_result_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                                reg_rd,
  output logic      [light_result_pkg::DATA_W-1:0] rd_data,
  output logic                                     rd_valid,
  output logic      [light_result_pkg::EXP_W-1:0]  thr_low_exp,
  output logic      [light_result_pkg::MHIGH_W-1:0] thr_low_result
);

  import light_result_pkg::*;

  ////////////////////////////////////////////////////////////////////////////

  logic [SLOT_COUNT-1:0][EXP_W-1:0]   exp_q;
  logic [SLOT_COUNT-1:0][EXP_W-1:0]   exp_d;
  logic [SLOT_COUNT-1:0][MHIGH_W-1:0] mhigh_q;
  logic [SLOT_COUNT-1:0][MHIGH_W-1:0] mhigh_d;
  logic [SLOT_COUNT-1:0][MLOW_W-1:0]  mlow_q;
  logic [SLOT_COUNT-1:0][MLOW_W-1:0]  mlow_d;
  logic [SLOT_COUNT-1:0][CNT_W-1:0]   cnt_q;
  logic [SLOT_COUNT-1:0][CNT_W-1:0]   cnt_d;
  logic [SLOT_COUNT-1:0][CHK_W-1:0]   chk_q;
  logic [SLOT_COUNT-1:0][CHK_W-1:0]   chk_d;
  logic [CNT_W-1:0]                   seq_q;
  logic [CNT_W-1:0]                   seq_d;
  logic [CHK_W-1:0]                   new_chk;
  logic [EXP_W-1:0]                   thr_exp_q;
  logic [EXP_W-1:0]                   thr_exp_d;
  logic [MHIGH_W-1:0]                 thr_res_q;
  logic [MHIGH_W-1:0]                 thr_res_d;
  logic [DATA_W-1:0]                  rd_data_q;
  logic [DATA_W-1:0]                  rd_data_d;
  logic                               rd_valid_q;
  logic                               rd_valid_d;
  logic                               thr_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Check bits of the incoming sample, taken with the count it will carry.

  light_check_bits u_check
  (
    .exp_in  (conv_exp),
    .mant_in (conv_light_fraction),
    .cnt_in  (seq_q),
    .chk_out (new_chk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sample slots: a finished conversion enters slot zero and the older ones
  // move down by one, so slot two always holds the oldest sample.

  for (genvar i = 0; i < SLOT_COUNT; i++)
  begin : g_slot
    if (i == 0)
    begin : g_head
      always_comb
      begin
        exp_d[i]   = exp_q[i];
        mhigh_d[i] = mhigh_q[i];
        mlow_d[i]  = mlow_q[i];
        cnt_d[i]   = cnt_q[i];
        chk_d[i]   = chk_q[i];
        if (conv_valid)
        begin
          exp_d[i]   = conv_exp;
          mhigh_d[i] = conv_light_fraction[MANT_W-1:MLOW_W];
          mlow_d[i]  = conv_light_fraction[MLOW_W-1:0];
          cnt_d[i]   = seq_q;
          chk_d[i]   = new_chk;
        end
      end
    end
    else
    begin : g_tail
      always_comb
      begin
        exp_d[i]   = exp_q[i];
        mhigh_d[i] = mhigh_q[i];
        mlow_d[i]  = mlow_q[i];
        cnt_d[i]   = cnt_q[i];
        chk_d[i]   = chk_q[i];
        if (conv_valid)
        begin
          exp_d[i]   = exp_q[i-1];
          mhigh_d[i] = mhigh_q[i-1];
          mlow_d[i]  = mlow_q[i-1];
          cnt_d[i]   = cnt_q[i-1];
          chk_d[i]   = chk_q[i-1];
        end
      end
    end

    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        exp_q[i]   <= RST_EXP;
        mhigh_q[i] <= RST_MHIGH;
        mlow_q[i]  <= RST_MLOW;
        cnt_q[i]   <= RST_CNT;
        chk_q[i]   <= RST_CHK;
      end
      else if (ce)
      begin
        exp_q[i]   <= exp_d[i];
        mhigh_q[i] <= mhigh_d[i];
        mlow_q[i]  <= mlow_d[i];
        cnt_q[i]   <= cnt_d[i];
        chk_q[i]   <= chk_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rolling conversion count; the four-bit width makes it wrap by itself.

  always_comb
  begin
    seq_d = seq_q;
    if (conv_valid)
    begin
      seq_d = seq_q + CNT_STEP;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      seq_q <= RST_CNT;
    end
    else if (ce)
    begin
      seq_q <= seq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low threshold. Only this offset accepts writes; a write anywhere else is
  // dropped so the buffered samples cannot be forged from the host side.

  assign thr_sel = (reg_addr == OFS_LOW_THRESHOLD);

  always_comb
  begin
    thr_exp_d = thr_exp_q;
    thr_res_d = thr_res_q;
    if (reg_wr && thr_sel)
    begin
      thr_exp_d = reg_wdata[POS_EXP_LSB +: EXP_W];
      thr_res_d = reg_wdata[POS_MHIGH_LSB +: MHIGH_W];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      thr_exp_q <= RST_EXP;
      thr_res_q <= RST_MHIGH;
    end
    else if (ce)
    begin
      thr_exp_q <= thr_exp_d;
      thr_res_q <= thr_res_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path. Data is registered so the host port sees a clean word one
  // cycle after the strobe; unmapped offsets read as zero.

  always_comb
  begin
    rd_valid_d = reg_rd;
    rd_data_d  = rd_data_q;
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_SLOT0_LOW_WORD:  rd_data_d = {mlow_q[0], cnt_q[0], chk_q[0]};
        OFS_SLOT1_HIGH_WORD: rd_data_d = {exp_q[1], mhigh_q[1]};
        OFS_SLOT1_LOW_WORD:  rd_data_d = {mlow_q[1], cnt_q[1], chk_q[1]};
        OFS_SLOT2_HIGH_WORD: rd_data_d = {exp_q[2], mhigh_q[2]};
        OFS_SLOT2_LOW_WORD:  rd_data_d = {mlow_q[2], cnt_q[2], chk_q[2]};
        OFS_LOW_THRESHOLD:   rd_data_d = {thr_exp_q, thr_res_q};
        default:             rd_data_d = RST_WORD;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data_q  <= RST_WORD;
      rd_valid_q <= 1'b0;
    end
    else if (ce)
    begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign rd_data        = rd_data_q;
  assign rd_valid       = rd_valid_q;
  assign thr_low_exp    = thr_exp_q;
  assign thr_low_result = thr_res_q;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_conv;
    ce && conv_valid;
  endsequence

  sequence s_read(logic [ADDR_W-1:0] a);
    ce && reg_rd && (reg_addr == a);
  endsequence

  chk_read_slot0_low: assert property (s_read(OFS_SLOT0_LOW_WORD) |=>
    rd_valid && rd_data == {$past(mlow_q[0]), $past(cnt_q[0]), $past(chk_q[0])})
    else $error("Slot zero low word read back wrong.");

  chk_read_slot1_high: assert property (s_read(OFS_SLOT1_HIGH_WORD) |=>
    rd_data == {$past(exp_q[1]), $past(mhigh_q[1])})
    else $error("Slot one high word read back wrong.");

  chk_read_slot1_low: assert property (s_read(OFS_SLOT1_LOW_WORD) |=>
    rd_data == {$past(mlow_q[1]), $past(cnt_q[1]), $past(chk_q[1])})
    else $error("Slot one low word read back wrong.");

  chk_read_slot2_high: assert property (s_read(OFS_SLOT2_HIGH_WORD) |=>
    rd_data == {$past(exp_q[2]), $past(mhigh_q[2])})
    else $error("Slot two high word read back wrong.");

  chk_read_slot2_low: assert property (s_read(OFS_SLOT2_LOW_WORD) |=>
    rd_data == {$past(mlow_q[2]), $past(cnt_q[2]), $past(chk_q[2])})
    else $error("Slot two low word read back wrong.");

  chk_thr_write_read: assert property (ce && reg_wr && thr_sel ##1 s_read(OFS_LOW_THRESHOLD) |=>
    rd_data == $past(reg_wdata, 2))
    else $error("Low threshold did not read back the written word.");

  chk_count_rolls: assert property (s_conv ##1 s_conv |=>
    cnt_q[0] == $past(cnt_q[0]) + CNT_STEP)
    else $error("Sample count did not advance by one.");

  chk_seq_steps: assert property (s_conv |=> seq_q == $past(seq_q) + CNT_STEP)
    else $error("Conversion count did not step on a conversion.");

  chk_range_shift: assert property (s_conv |=> exp_q[0] == $past(conv_exp) &&
    exp_q[1] == $past(exp_q[0]) && exp_q[2] == $past(exp_q[1]))
    else $error("Range exponent not carried through the slots.");

  chk_light_fraction_split: assert property (s_conv |=>
    {mhigh_q[0], mlow_q[0]} == $past(conv_light_fraction))
    else $error("Light_fraction halves do not form the sample.");

  chk_light_fraction_shift: assert property (s_conv |=>
    {mhigh_q[1], mlow_q[1]} == $past({mhigh_q[0], mlow_q[0]}))
    else $error("Light_fraction not carried from slot zero to slot one.");

  chk_check_top_bit: assert property (chk_q[1][3] == ^{mhigh_q[1][11], mhigh_q[1][3], mlow_q[1][3]})
    else $error("Check bit three wrong in slot one.");

  chk_check_parity: assert property (chk_q[0][0] == ^{exp_q[0], mhigh_q[0], mlow_q[0], cnt_q[0]})
    else $error("Check bit zero wrong in slot zero.");

  chk_ro_write_ignored: assert property (ce && reg_wr && !thr_sel && !conv_valid |=>
    $stable(exp_q) && $stable(mhigh_q) && $stable(mlow_q) && $stable(cnt_q) && $stable(chk_q))
    else $error("Write to a read-only slot changed it.");

endmodule

`default_nettype wire

// ---- rtl/light_result_pkg.sv ----
`default_nettype none

package light_result_pkg;

  // Widths of the host register port and of the stored fields.
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned EXP_W      = 4;
  localparam int unsigned MANT_W     = 20;
  localparam int unsigned MHIGH_W    = 12;
  localparam int unsigned MLOW_W     = 8;
  localparam int unsigned CNT_W      = 4;
  localparam int unsigned CHK_W      = 4;
  localparam int unsigned SLOT_COUNT = 3;

  // Register offsets on the host register port.
  localparam logic [ADDR_W-1:0] OFS_SLOT0_LOW_WORD  = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_SLOT1_HIGH_WORD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SLOT1_LOW_WORD  = 8'h05;
  localparam logic [ADDR_W-1:0] OFS_SLOT2_HIGH_WORD = 8'h06;
  localparam logic [ADDR_W-1:0] OFS_SLOT2_LOW_WORD  = 8'h07;
  localparam logic [ADDR_W-1:0] OFS_LOW_THRESHOLD   = 8'h08;

  // Field positions inside the 16-bit words.
  localparam int unsigned POS_EXP_LSB   = 12;
  localparam int unsigned POS_MHIGH_LSB = 0;
  localparam int unsigned POS_MLOW_LSB  = 8;
  localparam int unsigned POS_CNT_LSB   = 4;
  localparam int unsigned POS_CHK_LSB   = 0;

  // Values after reset.
  localparam logic [EXP_W-1:0]   RST_EXP   = 4'h0;
  localparam logic [MHIGH_W-1:0] RST_MHIGH = 12'h000;
  localparam logic [MLOW_W-1:0]  RST_MLOW  = 8'h00;
  localparam logic [CNT_W-1:0]   RST_CNT   = 4'h0;
  localparam logic [CHK_W-1:0]   RST_CHK   = 4'h0;
  localparam logic [DATA_W-1:0]  RST_WORD  = 16'h0000;
  localparam logic [CNT_W-1:0]   CNT_STEP  = 4'h1;

endpackage

`default_nettype wire

// ---- verif/tb.sv ----
`default_nettype none

module tb
  import light_result_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic                clk;
  logic                rst;
  logic                ce;
  logic                conv_valid;
  logic [EXP_W-1:0]    conv_exp;
  logic [MANT_W-1:0]   conv_light_fraction;
  logic [ADDR_W-1:0]   reg_addr;
  logic                reg_wr;
  logic [DATA_W-1:0]   reg_wdata;
  logic                reg_rd;
  logic [DATA_W-1:0]   rd_data;
  logic                rd_valid;
  logic [EXP_W-1:0]    thr_low_exp;
  logic [MHIGH_W-1:0]  thr_low_result;
  int                  mismatches;
  int                  checks_done;
  int                  cycles;
  logic [3:0]          m_exp [3];
  logic [19:0]         m_mant [3];
  logic [3:0]          m_cnt [3];
  logic [3:0]          cnt_next;

  light_result_fifo_regs DUT (
    .clk            (clk),
    .rst            (rst),
    .ce             (ce),
    .conv_valid     (conv_valid),
    .conv_exp       (conv_exp),
    .conv_light_fraction  (conv_light_fraction),
    .reg_addr       (reg_addr),
    .reg_wr         (reg_wr),
    .reg_wdata      (reg_wdata),
    .reg_rd         (reg_rd),
    .rd_data        (rd_data),
    .rd_valid       (rd_valid),
    .thr_low_exp    (thr_low_exp),
    .thr_low_result (thr_low_result)
  );

  always #50 clk = ~clk;

  // A hung handshake must not stall the run; the whole sequence needs far fewer cycles.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (mismatches == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [3:0] chk(input logic [3:0] e, input logic [19:0] r, input logic [3:0] c);
    logic [3:0] x;
    x[0] = ^{e, r, c};
    x[1] = c[1] ^ c[3] ^ (^(r & 20'hAAAAA)) ^ e[1] ^ e[3];
    x[2] = c[3] ^ r[3] ^ r[7] ^ r[11] ^ r[15] ^ r[19] ^ e[3];
    x[3] = r[3] ^ r[11] ^ r[19];
    return x;
  endfunction

  function automatic logic [15:0] low_word(input int i);
    return {m_mant[i][7:0], m_cnt[i], chk(m_exp[i], m_mant[i], m_cnt[i])};
  endfunction

  function automatic logic [15:0] high_word(input int i);
    return {m_exp[i], m_mant[i][19:8]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    cmp({15'h0000, rd_valid}, 16'h0001);
    cmp(rd_data, e);
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic check_slots();
    rd(OFS_SLOT0_LOW_WORD, low_word(0));
    rd(OFS_SLOT1_HIGH_WORD, high_word(1));
    rd(OFS_SLOT1_LOW_WORD, low_word(1));
    rd(OFS_SLOT2_HIGH_WORD, high_word(2));
    rd(OFS_SLOT2_LOW_WORD, low_word(2));
  endtask

  // Samples are held back to back so conv_valid never drops between them.
  task automatic convs(input int n, input logic [3:0] e0, input logic [19:0] m0);
    for (int i = 0; i < n; i++)
    begin
      conv_exp = e0 + 4'(i);
      conv_light_fraction = m0 + 20'(i) * 20'h1F3D5;
      conv_valid = 1'b1;
      @(negedge clk);
      for (int s = 2; s > 0; s--)
      begin
        m_exp[s] = m_exp[s-1];
        m_mant[s] = m_mant[s-1];
        m_cnt[s] = m_cnt[s-1];
      end
      m_exp[0] = conv_exp;
      m_mant[0] = conv_light_fraction;
      m_cnt[0] = cnt_next;
      cnt_next = cnt_next + 4'h1;
    end
    conv_valid = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check_slots();
    rd(OFS_LOW_THRESHOLD, 16'h0000);
    rd(8'h00, 16'h0000);
    rd(8'h09, 16'h0000);
    cmp({12'h000, thr_low_exp}, 16'h0000);
    cmp({4'h0, thr_low_result}, 16'h0000);
  endtask

  task automatic t_threshold();
    wr(OFS_LOW_THRESHOLD, 16'hA5C3);
    cmp({12'h000, thr_low_exp}, 16'h000A);
    cmp({4'h0, thr_low_result}, 16'h05C3);
    rd(OFS_LOW_THRESHOLD, 16'hA5C3);
    reg_wdata = 16'h1234;
    reg_wr = 1'b1;
    rd(OFS_LOW_THRESHOLD, 16'hA5C3);
    reg_wr = 1'b0;
    rd(OFS_LOW_THRESHOLD, 16'h1234);
    for (int a = 3; a < 8; a++)
      wr(8'(a), 16'hFFFF);
    check_slots();
  endtask

  task automatic t_conv();
    convs(3, 4'h3, 20'hABCDE);
    check_slots();
    convs(14, 4'hE, 20'h80F01);
    check_slots();
    convs(2, 4'h8, 20'hFFFFF);
    check_slots();
  endtask

  task automatic t_freeze();
    @(negedge clk);
    ce = 1'b0;
    conv_valid = 1'b1;
    reg_addr = OFS_LOW_THRESHOLD;
    reg_wdata = 16'h0F0F;
    reg_wr = 1'b1;
    reg_rd = 1'b1;
    @(negedge clk);
    cmp({15'h0000, rd_valid}, 16'h0000);
    conv_valid = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ce = 1'b1;
    cmp({thr_low_exp, thr_low_result}, 16'h1234);
    check_slots();
  endtask

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    conv_valid = 1'b0;
    conv_exp = 4'h0;
    conv_light_fraction = 20'h00000;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
    mismatches = 0;
    checks_done = 0;
    cycles = 0;
    cnt_next = 4'h0;
    for (int i = 0; i < 3; i++)
    begin
      m_exp[i] = 4'h0;
      m_mant[i] = 20'h00000;
      m_cnt[i] = 4'h0;
    end
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset();
    t_threshold();
    t_conv();
    t_freeze();
    stop_test();
  end

endmodule

`default_nettype wire
